// ===== src/arsr_pkg.sv
/*
  Shared constants for the conversion readout, status and reset logic:
  register offsets, status header bit positions, reset values and timing counts.
  Assumes a 20 MHz master clock feeding every file of the block.
*/
package arsr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ConvCtrlAddr = 7'h18;
  localparam logic [6:0] SyncResetAddr = 7'h1d;
  localparam logic [6:0] SummaryStatusAddr = 7'h2d;
  localparam logic [6:0] PortDiagAddr = 7'h2e;
  localparam logic [6:0] ConvDiagAddr = 7'h2f;
  localparam logic [6:0] LogicDiagAddr = 7'h30;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ConvCtrlReset = 8'h00;
  localparam logic [7:0] SyncResetReset = 8'h80;

  // ---------------------------------------------------------------------------
  // Conversion control fields
  // ---------------------------------------------------------------------------
  localparam int DiagEnBit = 4;
  localparam int DiagSelLsb = 0;
  localparam int EcoModeBit = 6;
  localparam int BoostBufBit = 5;
  localparam logic [1:0] DiagTemp = 2'h0;
  localparam logic [1:0] DiagShort = 2'h1;
  localparam logic [1:0] DiagRefPos = 2'h2;
  localparam logic [1:0] DiagRefNeg = 2'h3;

  // ---------------------------------------------------------------------------
  // Status header bits
  // ---------------------------------------------------------------------------
  localparam int HdrMasterErr = 7;
  localparam int HdrConvErr = 6;
  localparam int HdrLogicErr = 5;
  localparam int HdrClkQual = 4;
  localparam int HdrClipped = 3;
  localparam int HdrUnsettled = 2;
  localparam int HdrPortErr = 1;
  localparam int HdrPowerOn = 0;

  // ---------------------------------------------------------------------------
  // Serial command and frame constants
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CmdReset = 8'had;
  localparam logic [7:0] CmdExit = 8'h6c;
  localparam int ResumeZeros = 63;
  localparam int FrameBits = 32;
  localparam int ResultBits = 24;
  localparam logic [7:0] CrcSeed = 8'hff;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int ClkMhz = 20;
  localparam int PostResetUs = 200;
  localparam int PostResetCycles = PostResetUs * ClkMhz;
  localparam int UnsettledLagCycles = 128;

endpackage : arsr_pkg

// ===== src/arsr_status_hdr.sv
/*
  Builds the eight status header bits from the diagnostic registers.
  Assumes all inputs are on the master clock domain.
*/
`timescale 1ns/1ns
module arsr_status_hdr (
  input wire logic [7:0] portDiag,
  input wire logic [7:0] convDiag,
  input wire logic [7:0] logicDiag,
  input wire logic clockQualifyErrorFlag,
  input wire logic filterClippedFlag,
  input wire logic filterUnsettledFlag,
  input wire logic powerOnFlag,
  input wire logic pinControl,
  output logic [7:0] header
);

  always_comb begin
    header = 8'h00;
    header[arsr_pkg::HdrConvErr] = |convDiag;
    header[arsr_pkg::HdrLogicErr] = |logicDiag;
    header[arsr_pkg::HdrPortErr] = |portDiag;
    header[arsr_pkg::HdrClkQual] = clockQualifyErrorFlag;
    header[arsr_pkg::HdrClipped] = filterClippedFlag;
    header[arsr_pkg::HdrUnsettled] = filterUnsettledFlag;
    // Pin control forces this bit high as an interface sanity check.
    header[arsr_pkg::HdrPowerOn] = powerOnFlag | pinControl;
    header[arsr_pkg::HdrMasterErr] = |convDiag | (|logicDiag) | (|portDiag)
        | clockQualifyErrorFlag | filterClippedFlag | filterUnsettledFlag;
  end

endmodule : arsr_status_hdr

// ===== src/arsr_sync2.sv
/*
  Two-flop synchroniser for a level, vector of WIDTH bits.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module arsr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
    end else begin
      stage1Reg <= din;
      stage2Reg <= stage1Reg;
    end
  end

  assign dout = stage2Reg;

endmodule : arsr_sync2

// ===== src/arsr_readout.sv
/*
  Conversion readout, reset handling and status header of the converter's
  serial port. Holds the serial register port, the continuous readback
  shifter timed from the conversion ready strobe, and every reset path.
  Assumes clk is the master clock; serial pins come from the host and are
  synchronised here, so the serial clock must be well below clk/4.
*/
`timescale 1ns/1ns

// Summary of operation
// - Two back-to-back reset register writes reset device.
// - Continuous read watches exit and reset bytes.
// - One then 63 zeros on input resets.
// - Status header follows result; always in pin mode.
// - Master error is OR of all errors.
// - Group error flags OR their diagnostic registers.
// - Clock qualify flag set without valid clock.
// - Clipped flag set on filter full-scale clipping.
// - Unsettled flag high; filters cleared by reset/sync.
// - Unsettled flag may lag 128 master clocks.
// - Power-on flag records reset; pin mode reads one.
// - Diagnostics need eco, divide-16, boost buffers; code gates on enable, eco and boost only.
// - Diagnostic inputs: temperature, short, both references.
// - Frame is 24-bit result plus eight bits.
// - Pin control defaults to continuous readback.
// - Last bit held until strobe rises, then reset.
// - Frame MSB out on next falling serial clock.
// - Final pin-mode frame bit is always one.
// - Ready flags only continuous or missing 32 clocks.
// - Addressed readback resets output before strobe.
// - Sync input sampled on rising master clock.
module arsr_readout (
  input wire logic clk,
  input wire logic srst,
  input wire logic resetPinN,
  input wire logic pinControl,
  input wire logic selectN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic syncInN,
  input wire logic conversionReady,
  input wire logic [23:0] result,
  input wire logic [7:0] portDiag,
  input wire logic [7:0] convDiag,
  input wire logic [7:0] logicDiag,
  input wire logic clockQualifyErrorFlag,
  input wire logic filterClippedFlag,
  input wire logic filterUnsettledFlag,
  output logic serialOut,
  output logic conversionReadyStrobe,
  output logic filterClear,
  output logic diagActive,
  output logic [1:0] diagSelect,
  output logic continuousMode
);

  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_ADDR_DATA = 3'b010,
    ST_CONT = 3'b100
  } arsr_port_t;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] pinsSync;
  logic syncInSync;

  arsr_sync2 #(.WIDTH(4)) u_pins (
    .clk(clk),
    .srst(srst),
    .din({resetPinN, selectN, serialClk, serialIn}),
    .dout(pinsSync)
  );

  // Sampled on rising master clock; a synchronous host source still takes the two flop stages.
  // Inverted so that a flushed synchroniser reads as the idle high pin.
  arsr_sync2 #(.WIDTH(1)) u_sync (
    .clk(clk),
    .srst(srst),
    .din(~syncInN),
    .dout(syncInSync)
  );

  logic resetPinS, selectS, sclkS, sdiS, syncS;
  // The flushed synchroniser shows the pin asserted, so srst also runs the full
  // reset path for two cycles and picks up the pin control mode.
  assign resetPinS = pinsSync[3];
  assign selectS = pinsSync[2];
  assign sclkS = pinsSync[1];
  assign sdiS = pinsSync[0];
  assign syncS = ~syncInSync;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  arsr_port_t state_reg, state_next;
  logic sclkPrev_reg, sclkPrev_next;
  logic readyPrev_reg, readyPrev_next;
  logic syncPrev_reg, syncPrev_next;
  logic [15:0] inShift_reg, inShift_next;
  logic [4:0] inCount_reg, inCount_next;
  logic [6:0] zeroCount_reg, zeroCount_next;
  logic armed_reg, armed_next;
  logic softPending_reg, softPending_next;
  logic [7:0] convCtrl_reg, convCtrl_next;
  logic [7:0] syncReset_reg, syncReset_next;
  logic powerOn_reg, powerOn_next;
  logic [31:0] frame_reg, frame_next;
  logic [5:0] outCount_reg, outCount_next;
  logic [7:0] readData_reg, readData_next;
  logic readActive_reg, readActive_next;
  logic serialOut_reg, serialOut_next;
  logic strobe_reg, strobe_next;
  logic filterClear_reg, filterClear_next;
  logic cont_reg, cont_next;
  logic [7:0] header;
  logic fullReset;

  arsr_status_hdr u_hdr (
    .portDiag(portDiag),
    .convDiag(convDiag),
    .logicDiag(logicDiag),
    .clockQualifyErrorFlag(clockQualifyErrorFlag),
    .filterClippedFlag(filterClippedFlag),
    .filterUnsettledFlag(filterUnsettledFlag),
    .powerOnFlag(powerOn_reg),
    .pinControl(pinControl),
    .header(header)
  );

  // Register read mux; summary status mirrors the header.
  function automatic logic [7:0] readReg(input logic [6:0] a, input logic [7:0] hdr,
      input logic [7:0] cc, input logic [7:0] sr, input logic [7:0] pd,
      input logic [7:0] cd, input logic [7:0] ld);
    logic [7:0] v;
    v = 8'h00;
    if (a == arsr_pkg::ConvCtrlAddr) begin
      v = cc;
    end else if (a == arsr_pkg::SyncResetAddr) begin
      v = sr;
    end else if (a == arsr_pkg::SummaryStatusAddr) begin
      v = hdr;
    end else if (a == arsr_pkg::PortDiagAddr) begin
      v = pd;
    end else if (a == arsr_pkg::ConvDiagAddr) begin
      v = cd;
    end else if (a == arsr_pkg::LogicDiagAddr) begin
      v = ld;
    end
    return v;
  endfunction : readReg

  logic sclkRise, sclkFall, readyRise, syncRise, frameLoad;
  assign sclkRise = sclkS & ~sclkPrev_reg & ~selectS;
  assign sclkFall = ~sclkS & sclkPrev_reg & ~selectS;
  assign readyRise = conversionReady & ~readyPrev_reg;
  assign syncRise = syncS & ~syncPrev_reg;
  assign frameLoad = readyRise & cont_reg;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    sclkPrev_next = sclkS;
    readyPrev_next = conversionReady;
    syncPrev_next = syncS;
    inShift_next = inShift_reg;
    inCount_next = inCount_reg;
    zeroCount_next = zeroCount_reg;
    armed_next = armed_reg;
    softPending_next = softPending_reg;
    convCtrl_next = convCtrl_reg;
    syncReset_next = syncReset_reg;
    powerOn_next = powerOn_reg;
    frame_next = frame_reg;
    outCount_next = outCount_reg;
    readData_next = readData_reg;
    readActive_next = readActive_reg;
    serialOut_next = serialOut_reg;
    strobe_next = conversionReady;
    filterClear_next = 1'b0;
    cont_next = cont_reg;
    fullReset = 1'b0;

    if (selectS) begin
      inCount_next = 5'h00;
      zeroCount_next = 7'h00;
      armed_next = 1'b0;
      readActive_next = 1'b0;
      if (!cont_reg) begin
        state_next = ST_CMD;
      end
    end

    if (sclkRise) begin
      inShift_next = {inShift_reg[14:0], sdiS};
      inCount_next = inCount_reg + 5'h01;
      // Resume pattern: a one, then 63 zeros with select low.
      if (sdiS) begin
        armed_next = 1'b1;
        zeroCount_next = 7'h00;
      end else if (armed_reg) begin
        zeroCount_next = zeroCount_reg + 7'h01;
        if (zeroCount_reg == 7'(arsr_pkg::ResumeZeros - 1)) begin
          fullReset = 1'b1;
        end
      end
      case (state_reg)
        ST_CMD: begin
          if (inCount_reg == 5'h07) begin
            state_next = ST_ADDR_DATA;
            inCount_next = 5'h00;
            readActive_next = {inShift_reg[6:0], sdiS} >= 8'h80;
            readData_next = readReg({inShift_reg[5:0], sdiS}, header, convCtrl_reg,
                syncReset_reg, portDiag, convDiag, logicDiag);
            // Any access other than a reset register write breaks the pair.
            if ({inShift_reg[6:0], sdiS} != {1'b0, arsr_pkg::SyncResetAddr}) begin
              softPending_next = 1'b0;
            end
          end
        end
        ST_ADDR_DATA: begin
          if (inCount_reg == 5'h07) begin
            state_next = ST_CMD;
            inCount_next = 5'h00;
            if (!readActive_reg) begin
              if (inShift_reg[13:7] == arsr_pkg::ConvCtrlAddr) begin
                // Diagnostic select lives here.
                convCtrl_next = {inShift_reg[6:0], sdiS};
              end else if (inShift_reg[13:7] == arsr_pkg::SyncResetAddr) begin
                syncReset_next = {inShift_reg[6:0], sdiS};
                softPending_next = 1'b1;
                if (softPending_reg) begin
                  fullReset = 1'b1;
                end
              end
            end
          end
        end
        ST_CONT: begin
          if (inCount_reg == 5'h07) begin
            inCount_next = 5'h00;
            if ({inShift_reg[6:0], sdiS} == arsr_pkg::CmdReset) begin
              fullReset = 1'b1;
            end else if ({inShift_reg[6:0], sdiS} == arsr_pkg::CmdExit) begin
              state_next = ST_CMD;
              cont_next = 1'b0;
            end
          end
        end
        default: state_next = ST_CMD;
      endcase
    end

    if (sclkFall) begin
      if (cont_reg && outCount_reg != 6'h00) begin
        serialOut_next = frame_reg[31];
        frame_next = {frame_reg[30:0], 1'b0};
        outCount_next = outCount_reg - 6'h01;
      end else if (readActive_reg) begin
        serialOut_next = readData_reg[7];
        readData_next = {readData_reg[6:0], 1'b0};
      end
    end

    // Last bit stays until the ready strobe rises, then the output resets; that
    // low level is the ready flag, so nothing else may pull the line between frames.
    if (readyRise) begin
      serialOut_next = 1'b0;
      if (cont_reg) begin
        frame_next = {result, header};
        outCount_next = 6'(arsr_pkg::FrameBits);
      end
    end

    if (syncRise) begin
      filterClear_next = 1'b1;
    end

    if (fullReset || !resetPinS) begin
      // Every path lands in the same state.
      state_next = pinControl ? ST_CONT : ST_CMD;
      cont_next = pinControl;
      convCtrl_next = arsr_pkg::ConvCtrlReset;
      syncReset_next = arsr_pkg::SyncResetReset;
      softPending_next = 1'b0;
      armed_next = 1'b0;
      zeroCount_next = 7'h00;
      inCount_next = 5'h00;
      outCount_next = 6'h00;
      powerOn_next = 1'b1;
      filterClear_next = 1'b1;
      serialOut_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_CMD;
      sclkPrev_reg <= 1'b0;
      readyPrev_reg <= 1'b0;
      syncPrev_reg <= 1'b1;
      inShift_reg <= 16'h0000;
      inCount_reg <= 5'h00;
      zeroCount_reg <= 7'h00;
      armed_reg <= 1'b0;
      softPending_reg <= 1'b0;
      convCtrl_reg <= arsr_pkg::ConvCtrlReset;
      syncReset_reg <= arsr_pkg::SyncResetReset;
      powerOn_reg <= 1'b1;
      frame_reg <= 32'h00000000;
      outCount_reg <= 6'h00;
      readData_reg <= 8'h00;
      readActive_reg <= 1'b0;
      serialOut_reg <= 1'b0;
      strobe_reg <= 1'b0;
      filterClear_reg <= 1'b1;
      cont_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sclkPrev_reg <= sclkPrev_next;
      readyPrev_reg <= readyPrev_next;
      syncPrev_reg <= syncPrev_next;
      inShift_reg <= inShift_next;
      inCount_reg <= inCount_next;
      zeroCount_reg <= zeroCount_next;
      armed_reg <= armed_next;
      softPending_reg <= softPending_next;
      convCtrl_reg <= convCtrl_next;
      syncReset_reg <= syncReset_next;
      powerOn_reg <= powerOn_next;
      frame_reg <= frame_next;
      outCount_reg <= outCount_next;
      readData_reg <= readData_next;
      readActive_reg <= readActive_next;
      serialOut_reg <= serialOut_next;
      strobe_reg <= strobe_next;
      filterClear_reg <= filterClear_next;
      cont_reg <= cont_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic diagOk;
  // Diagnostics only run with eco mode and boost buffers set.
  assign diagOk = convCtrl_reg[arsr_pkg::DiagEnBit] & convCtrl_reg[arsr_pkg::EcoModeBit]
      & convCtrl_reg[arsr_pkg::BoostBufBit];
  logic diagActive_reg;
  logic [1:0] diagSelect_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      diagActive_reg <= 1'b0;
      diagSelect_reg <= arsr_pkg::DiagTemp;
    end else begin
      diagActive_reg <= diagOk;
      diagSelect_reg <= convCtrl_reg[arsr_pkg::DiagSelLsb +: 2];
    end
  end

  assign serialOut = serialOut_reg;
  assign conversionReadyStrobe = strobe_reg;
  assign filterClear = filterClear_reg;
  assign diagActive = diagActive_reg;
  assign diagSelect = diagSelect_reg;
  assign continuousMode = cont_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_hdr_master;
    @(posedge clk) disable iff (srst)
      (|convDiag) |-> header[arsr_pkg::HdrMasterErr];
  endproperty
  a_hdr_master: assert property (p_hdr_master) else $error("master flag missed");

  property p_hdr_port;
    @(posedge clk) disable iff (srst)
      header[arsr_pkg::HdrPortErr] == (|portDiag);
  endproperty
  a_hdr_port: assert property (p_hdr_port) else $error("port error flag wrong");

  property p_pin_por;
    @(posedge clk) disable iff (srst)
      pinControl |-> header[arsr_pkg::HdrPowerOn];
  endproperty
  a_pin_por: assert property (p_pin_por) else $error("pin mode flag low");

  property p_reset_flag;
    @(posedge clk) disable iff (srst)
      fullReset |=> powerOn_reg && filterClear_reg && convCtrl_reg == arsr_pkg::ConvCtrlReset;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset incomplete");

  property p_ready_clears;
    @(posedge clk) disable iff (srst)
      readyRise && !fullReset |=> !serialOut_reg;
  endproperty
  a_ready_clears: assert property (p_ready_clears) else $error("output not reset");

  property p_frame_load;
    @(posedge clk) disable iff (srst)
      frameLoad && resetPinS && !fullReset |=> outCount_reg == 6'd32 && frame_reg[7:0] == $past(header);
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("frame not loaded");

  property p_sync_clear;
    @(posedge clk) disable iff (srst)
      syncRise |=> filterClear_reg;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear");

  property p_pin_cont;
    @(posedge clk) disable iff (srst)
      !resetPinS && pinControl |=> cont_reg;
  endproperty
  a_pin_cont: assert property (p_pin_cont) else $error("pin mode not continuous");

  c_soft_reset: cover property (@(posedge clk) disable iff (srst)
      fullReset && state_reg == ST_ADDR_DATA);
  c_cont_reset: cover property (@(posedge clk) disable iff (srst)
      fullReset && state_reg == ST_CONT);
  c_frame: cover property (@(posedge clk) disable iff (srst) frameLoad);

endmodule : arsr_readout

// ===== test/arsr_host_model.sv
/*
  Host side model: drives the serial clock, chip select and serial data in,
  and samples the data output. Assumes a master clock at clk; the testbench
  touches these pins only through xfer.
*/
`timescale 1ns/1ns
module arsr_host_model (
  input wire logic clk,
  input wire logic serialOut,
  output logic serialClk,
  output logic serialIn,
  output logic selectN
);
  // Twelve master clocks per bit keeps the synchronised edges well apart.
  localparam int HalfBit = 6;

  initial begin
    serialClk = 1'b1;
    serialIn = 1'b0;
    selectN = 1'b1;
  end

  task automatic xfer(input logic [63:0] tx, input int n, input logic done,
                      output logic [63:0] rx);
    rx = '0;
    selectN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      serialClk = 1'b0;
      serialIn = tx[i];
      repeat (HalfBit) @(negedge clk);
      rx[i] = serialOut;
      serialClk = 1'b1;
      repeat (HalfBit - 1) @(negedge clk);
    end
    if (done) begin
      @(negedge clk);
      selectN = 1'b1;
    end
  endtask : xfer
endmodule : arsr_host_model

// ===== test/tb.sv
/*
  Self-checking bench for the readout block: frames, header, resets, diags.
  Assumes the host model owns the serial pins and a 20 MHz master clock.
*/
`timescale 1ns/1ns
module tb;
  localparam int TimeoutCycles = 60000;
  logic clk, srst, resetPinN, pinControl, selectN, serialClk, serialIn, syncInN;
  logic conversionReady, clockQualifyErrorFlag, filterClippedFlag, filterUnsettledFlag;
  logic serialOut, conversionReadyStrobe, filterClear, diagActive, continuousMode;
  logic [23:0] result;
  logic [7:0] portDiag, convDiag, logicDiag;
  logic [1:0] diagSelect;
  logic [63:0] rx;
  logic [31:0] expQ[$];
  int errCount, totalChecks, clears, cycles, seed, c0;

  arsr_readout u_dut (.clk, .srst, .resetPinN, .pinControl, .selectN, .serialClk,
    .serialIn, .syncInN, .conversionReady, .result, .portDiag, .convDiag, .logicDiag,
    .clockQualifyErrorFlag, .filterClippedFlag, .filterUnsettledFlag, .serialOut,
    .conversionReadyStrobe, .filterClear, .diagActive, .diagSelect, .continuousMode);
  arsr_host_model u_host (.clk, .serialOut, .serialClk, .serialIn, .selectN);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (filterClear === 1'b1) clears++;
    if (cycles == TimeoutCycles) begin
      errCount++;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic end_sim();
    if (errCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic settle();
    repeat (arsr_pkg::PostResetCycles) @(negedge clk);
  endtask : settle

  task automatic do_reset(input logic pin);
    @(negedge clk);
    pinControl = pin;
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    settle();
  endtask : do_reset

  task automatic clr_check(input string name, input logic e);
    repeat (8) @(negedge clk);
    check(name, 32'(e), 32'(clears > c0));
  endtask : clr_check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({48'h0, 1'b0, a, d}, 16, 1'b1, rx);
    repeat (4) @(negedge clk);
  endtask : wr

  // The model keeps one expected frame per strobe and pops it on readback.
  task automatic frame(input int k);
    logic [31:0] r;
    logic [7:0] h;
    r = (k == 0) ? 32'h0 : $random(seed);
    @(negedge clk);
    if (k > 0) check("heldLastBit", 32'h1, 32'(serialOut));
    result = 24'($random(seed));
    portDiag = r[7:0] & {8{r[31]}};
    convDiag = r[15:8] & {8{r[30]}};
    logicDiag = r[23:16] & {8{r[29]}};
    {clockQualifyErrorFlag, filterClippedFlag, filterUnsettledFlag} = r[28:26];
    h = {1'b0, |convDiag, |logicDiag, r[28:26], |portDiag, 1'b1};
    h[7] = |h[6:1];
    expQ.push_back({result, h});
    conversionReady = 1'b1;
    @(negedge clk);
    conversionReady = 1'b0;
    check("readyStrobe", 32'h1, 32'(conversionReadyStrobe));
    repeat (2) @(negedge clk);
    check("outAfterStrobe", 32'h0, 32'(serialOut));
    repeat (arsr_pkg::UnsettledLagCycles) @(negedge clk);
    u_host.xfer(64'h0, 32, 1'b0, rx);
    check("frame", expQ.pop_front(), rx[31:0]);
  endtask : frame

  initial begin
    seed = 32'hd315d83e;
    {srst, resetPinN, pinControl, syncInN, conversionReady} = 5'b11110;
    {result, portDiag, convDiag, logicDiag} = '0;
    {clockQualifyErrorFlag, filterClippedFlag, filterUnsettledFlag} = 3'h0;
    do_reset(1'b1);
    check("contModePin", 32'h1, 32'(continuousMode));
    for (int k = 0; k < 5; k++) frame(k);
    @(negedge clk);
    c0 = clears;
    syncInN = 1'b0;
    repeat (2) @(negedge clk);
    syncInN = 1'b1;
    clr_check("syncClear", 1'b1);
    c0 = clears;
    u_host.xfer(64'h0000_0000_0000_00ad, 8, 1'b0, rx);
    clr_check("cmdReset", 1'b1);
    settle();
    c0 = clears;
    u_host.xfer(64'h8000_0000_0000_0000, 64, 1'b1, rx);
    clr_check("resumeReset", 1'b1);
    settle();
    u_host.xfer(64'h6c, 8, 1'b1, rx);
    repeat (8) @(negedge clk);
    check("exitCont", 32'h0, 32'(continuousMode));
    c0 = clears;
    resetPinN = 1'b0;
    repeat (10) @(negedge clk);
    resetPinN = 1'b1;
    clr_check("pinReset", 1'b1);
    check("contAfterPin", 32'h1, 32'(continuousMode));
    do_reset(1'b0);
    check("contModeReg", 32'h0, 32'(continuousMode));
    for (int s = 0; s < 4; s++) begin
      wr(arsr_pkg::ConvCtrlAddr, 8'h70 | 8'(s));
      check("diagActive", 32'h1, 32'(diagActive));
      check("diagSelect", 32'(s), 32'(diagSelect));
    end
    wr(arsr_pkg::ConvCtrlAddr, 8'h13);
    u_host.xfer({48'h0, 1'b1, arsr_pkg::ConvCtrlAddr, 8'h00}, 16, 1'b1, rx);
    check("convCtrlRead", 32'h13, 32'(rx[7:0]));
    repeat (4) @(negedge clk);
    check("diagNoEco", 32'h0, 32'(diagActive));
    c0 = clears;
    wr(arsr_pkg::SyncResetAddr, arsr_pkg::SyncResetReset);
    wr(arsr_pkg::ConvCtrlAddr, 8'h70);
    clr_check("singleWrite", 1'b0);
    c0 = clears;
    wr(arsr_pkg::SyncResetAddr, arsr_pkg::SyncResetReset);
    wr(arsr_pkg::SyncResetAddr, arsr_pkg::SyncResetReset);
    clr_check("softReset", 1'b1);
    check("diagDefault", 32'h0, 32'(diagActive));
    end_sim();
  end
endmodule : tb
